// [reset_timeout_sequencer.sv]
// Reset and start-up time-out sequencer with reset-cause flags and APB registers
`timescale 1ns/100ps
module reset_timeout_sequencer
    import rst_pkg::*;
#(
    parameter int POWERUP_TIMER_COUNT = POWERUP_TIMER_TICKS,  // Low-frequency ticks of the power-up delay
    parameter int OST_COUNT = OST_PERIODS,  // Main oscillator periods of the start-up count
    parameter int BOR_MIN_CYCLES = 16       // Minimum brown-out duration in pclk cycles
) (
    input wire logic pclk,              // System clock, 250 MHz
    input wire logic presetn,           // Async reset, active low (power-on)
    input wire logic psel,              // APB select
    input wire logic penable,           // APB enable
    input wire logic pwrite,            // APB direction
    input wire logic [11:0] paddr,      // APB byte address
    input wire logic [31:0] pwdata,     // APB write data
    output logic [31:0] prdata,         // APB read data
    output logic pready,                // APB ready
    output logic pslverr,               // APB error, unmapped address
    input wire logic ext_reset_pin_in,  // External reset pin level, active low
    output logic ext_reset_pin_out,     // Pin output value, always low when driven
    output logic ext_reset_pin_oe_n,    // Pin output enable, low drives; never driven
    output logic ext_reset_pin_pullup,  // Weak pull-up enable on the pin
    input wire logic supply_low,        // Supply below brown-out threshold (async)
    input wire logic low_freq_internal_osc, // 31 kHz oscillator (sampled)
    input wire logic main_osc,          // Selected main oscillator (sampled)
    input wire logic watchdog_timeout,  // Watchdog expiry, one-cycle pulse
    input wire logic sleep_active,      // Core is asleep
    input wire logic prog_entry_in,     // Programming-mode entry detect on the pin
    output logic prog_entry,            // Programming-mode request to the core
    output logic core_reset_n,          // Internal reset to the core, active low
    output logic core_clk_internal,     // Core runs from the internal oscillator
    output logic wake_pending           // Start-up count running after wake
);
    initial begin
        if (POWERUP_TIMER_COUNT < 1 || POWERUP_TIMER_COUNT > 65535 || OST_COUNT < 1 || OST_COUNT > 65535) begin
            $error("reset_timeout_sequencer: counts out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    logic pin_f;
    logic low_f;
    logic lf_f;
    logic mo_f;
    logic lf_d;
    logic mo_d;
    pin_filter #(.INIT(1'b0)) u_pin (.pclk(pclk), .presetn(presetn),
        .din(ext_reset_pin_in), .dout(pin_f));
    pin_filter #(.INIT(1'b1)) u_low (.pclk(pclk), .presetn(presetn),
        .din(supply_low), .dout(low_f));
    pin_filter #(.INIT(1'b0)) u_lf (.pclk(pclk), .presetn(presetn),
        .din(low_freq_internal_osc), .dout(lf_f));
    pin_filter #(.INIT(1'b0)) u_mo (.pclk(pclk), .presetn(presetn),
        .din(main_osc), .dout(mo_f));
    wire lf_tick = lf_f & ~lf_d;
    wire mo_tick = mo_f & ~mo_d;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] cfg;
    logic [7:0] status;
    logic [7:0] pwrctl;
    logic [7:0] events;
    wire powerup_timer_en = ~cfg[CFG_POWERUP_TIMER_BIT];
    wire ext_reset_pin_enable = cfg[CFG_EXT_RESET_PIN_ENABLE_BIT];
    wire [1:0] bor_mode = cfg[CFG_BORM_LSB +: 2];
    wire [2:0] osc_mode = cfg[CFG_OSC_LSB +: 3];
    wire two_speed = cfg[CFG_TWOSPD_BIT];
    wire crystal = (osc_mode == OSC_LP) || (osc_mode == OSC_XT) || (osc_mode == OSC_HS);

    // Brown-out enable per mode
    logic bor_en;
    always_comb begin
        unique case (bor_mode)
            BOR_OFF: bor_en = 1'b0;
            BOR_SW: bor_en = pwrctl[SBOR_BIT];
            BOR_NOSLEEP: bor_en = ~sleep_active;
            BOR_ON: bor_en = 1'b1;
        endcase
    end

    // Pin reset, tied inactive when the pin function is off
    wire pin_reset = ext_reset_pin_enable & ~pin_f;

    ////////////////////////////////////////////////////////////////////////
    // Brown-out detect with minimum duration
    logic [15:0] low_cnt;
    wire bor_hit = bor_en && low_f && (low_cnt >= 16'(BOR_MIN_CYCLES));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 16'h0000;
        end else if (bor_en && low_f) begin
            if (low_cnt != 16'hFFFF) begin
                low_cnt <= low_cnt + 16'h0001;
            end
        end else begin
            low_cnt <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time-out sequencer
    seq_state_t state;
    seq_state_t next_state;
    logic [15:0] cnt;
    logic wake_ost;
    wire wake_req = sleep_active & watchdog_timeout;
    wire wdt_reset = ~sleep_active & watchdog_timeout;
    wire hold_supply = bor_en & low_f;
    wire powerup_timer_done = lf_tick && (cnt == 16'(POWERUP_TIMER_COUNT - 1));
    wire ost_done = mo_tick && (cnt == 16'(OST_COUNT - 1));

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_HOLD: begin
                if (!hold_supply) begin
                    next_state = powerup_timer_en ? ST_POWERUP_TIMER : (crystal ? ST_OST : ST_PIN);
                end
            end
            ST_POWERUP_TIMER: begin
                if (powerup_timer_done) begin
                    next_state = crystal ? ST_OST : ST_PIN;
                end
            end
            ST_OST: begin
                if (ost_done) begin
                    next_state = ST_PIN;
                end
            end
            ST_PIN: begin
                if (!pin_reset) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pin_reset || wdt_reset) begin
                    next_state = ST_PIN;
                end
            end
        endcase
        if (bor_hit) begin
            next_state = ST_HOLD;
        end
    end

    // State, counter and wake start-up tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_HOLD;
            cnt <= 16'h0000;
            wake_ost <= 1'b0;
            lf_d <= 1'b0;
            mo_d <= 1'b0;
        end else begin
            lf_d <= lf_f;
            mo_d <= mo_f;
            state <= next_state;
            if (next_state != state || bor_hit) begin
                cnt <= 16'h0000;
            end else if ((state == ST_POWERUP_TIMER && lf_tick) || (state == ST_OST && mo_tick)) begin
                cnt <= cnt + 16'h0001;
            end else if (wake_ost && mo_tick) begin
                cnt <= cnt + 16'h0001;
            end
            if (state == ST_RUN && wake_req && crystal) begin
                wake_ost <= 1'b1;
            end else if (wake_ost && ost_done) begin
                wake_ost <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered; release on a clean pclk edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_n <= 1'b0;
            core_clk_internal <= 1'b0;
            wake_pending <= 1'b0;
            ext_reset_pin_pullup <= 1'b0;
            prog_entry <= 1'b0;
            ext_reset_pin_out <= 1'b0;
            ext_reset_pin_oe_n <= 1'b1;
        end else begin
            core_reset_n <= (next_state == ST_RUN) ||
                            (next_state == ST_OST && two_speed);
            core_clk_internal <= (next_state == ST_OST) && two_speed;
            wake_pending <= wake_ost;
            ext_reset_pin_pullup <= ~ext_reset_pin_enable;
            prog_entry <= prog_entry_in;
            ext_reset_pin_out <= 1'b0;
            ext_reset_pin_oe_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire [9:0] word_addr = paddr[11:2] << 0;
    wire hit_status = (paddr[11:2] == STATUS_ADDR[9:0] >> 2) && paddr[1:0] == 2'b00;
    wire hit_pwrctl = (paddr[11:2] == PWRCTL_ADDR[9:0] >> 2) && paddr[1:0] == 2'b00;
    wire hit_cfg = (paddr[11:2] == CONFIG_ADDR[9:0] >> 2) && paddr[1:0] == 2'b00;
    wire hit_evt = (paddr[11:2] == EVENT_ADDR[9:0] >> 2) && paddr[1:0] == 2'b00;
    wire mapped = hit_status | hit_pwrctl | hit_cfg | hit_evt;
    wire acc = psel & penable;
    wire wr = acc & pwrite & mapped;
    wire [7:0] rd_mux = hit_status ? status : hit_pwrctl ? pwrctl :
                        hit_cfg ? cfg : hit_evt ? events : 8'h00;
    wire enter_reset = (state == ST_RUN) && (next_state != ST_RUN);
    wire was_bor = bor_hit && state != ST_HOLD;

    // Register writes and reset-cause flags; hardware events win over writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= CONFIG_RESET;
            status <= STATUS_RESET;
            pwrctl <= PWRCTL_RESET & ~(8'h01 << POR_BIT);
            events <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~pready;
            pslverr <= psel & ~pready & ~mapped;
            prdata <= {24'h000000, rd_mux};
            // Writes land at the access edge where pready is high
            if (wr && hit_cfg && pready) begin
                cfg <= pwdata[7:0];
            end
            if (wr && hit_status && pready) begin
                status <= {pwdata[7:5], status[TO_BIT], status[PD_BIT], pwdata[2:0]};
            end
            if (wr && hit_pwrctl && pready) begin
                pwrctl <= {3'h0, pwdata[SBOR_BIT], 2'h0, pwdata[POR_BIT], pwdata[BOR_BIT]};
            end
            // Clear comes first so a same-cycle event still sets its bit
            if (wr && hit_evt && pready) begin
                events <= events & ~pwdata[7:0];
            end
            if (was_bor) begin
                pwrctl[BOR_BIT] <= 1'b0;
                status[TO_BIT] <= 1'b1;
                status[PD_BIT] <= 1'b1;
                events[0] <= 1'b1;
            end else if (watchdog_timeout && sleep_active) begin
                status[TO_BIT] <= 1'b0;
                status[PD_BIT] <= 1'b0;
            end else if (wdt_reset && enter_reset) begin
                status[TO_BIT] <= 1'b0;
                events[1] <= 1'b1;
            end else if (pin_reset && sleep_active && state == ST_RUN) begin
                status[TO_BIT] <= 1'b1;
                status[PD_BIT] <= 1'b0;
                events[2] <= 1'b1;
            end
        end
    end
    wire unused_ok = |word_addr;
endmodule

// [rst_pkg.sv]
// Package with register map, field positions, modes and timing constants for the reset sequencer
package rst_pkg;
    // Register byte addresses (printed offsets are not all multiples of four: index * 4)
    localparam logic [7:0] STATUS_IDX = 8'h03;
    localparam logic [7:0] PWRCTL_IDX = 8'h8E;
    localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
    localparam logic [9:0] PWRCTL_ADDR = {PWRCTL_IDX, 2'b00};
    localparam logic [9:0] CONFIG_ADDR = 10'h300;
    localparam logic [9:0] EVENT_ADDR = 10'h304;
    // Field positions
    localparam int TO_BIT = 4;
    localparam int PD_BIT = 3;
    localparam int SBOR_BIT = 4;
    localparam int POR_BIT = 1;
    localparam int BOR_BIT = 0;
    // Configuration register fields
    localparam int CFG_POWERUP_TIMER_BIT = 0;
    localparam int CFG_EXT_RESET_PIN_ENABLE_BIT = 1;
    localparam int CFG_BORM_LSB = 2;
    localparam int CFG_OSC_LSB = 4;
    localparam int CFG_TWOSPD_BIT = 7;
    localparam logic [7:0] CONFIG_RESET = 8'h02;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] PWRCTL_RESET = 8'h11;
    // Brown-out modes
    localparam logic [1:0] BOR_OFF = 2'h0;
    localparam logic [1:0] BOR_SW = 2'h1;
    localparam logic [1:0] BOR_NOSLEEP = 2'h2;
    localparam logic [1:0] BOR_ON = 2'h3;
    // Oscillator modes that need the start-up count
    localparam logic [2:0] OSC_LP = 3'h0;
    localparam logic [2:0] OSC_XT = 3'h1;
    localparam logic [2:0] OSC_HS = 3'h2;
    // Timing
    localparam int LFOSC_HZ = 31000;
    localparam int POWERUP_TIMER_MS = 64;
    localparam int POWERUP_TIMER_TICKS = LFOSC_HZ * POWERUP_TIMER_MS / 1000;
    localparam int OST_PERIODS = 1024;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [2:0] {ST_HOLD, ST_POWERUP_TIMER, ST_OST, ST_PIN, ST_RUN} seq_state_t;
endpackage

// [pin_filter.sv]
// Three-stage synchroniser with agreement filter for an asynchronous input
`timescale 1ns/100ps
module pin_filter #(
    parameter logic INIT = 1'b1
) (
    input wire logic pclk,      // System clock
    input wire logic presetn,   // Async reset, active low
    input wire logic din,       // Asynchronous input
    output logic dout           // Filtered level
);
    logic s1;
    logic s2;
    logic s3;
    wire agree = (s2 == s3);

    // Shift chain; first stage only feeds the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            dout <= INIT;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (agree) begin
                dout <= s3;
            end
        end
    end
endmodule

// [rts_properties.sv]
// Port-level checks for the reset sequencer, bound into the design
`timescale 1ns/100ps
module rts_properties
    import rst_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic ext_reset_pin_in, // Pin level
    input wire logic ext_reset_pin_out, // Pin value
    input wire logic ext_reset_pin_oe_n, // Pin enable
    input wire logic ext_reset_pin_pullup, // Pull-up
    input wire logic supply_low, // Supply low
    input wire logic prog_entry_in, // Entry detect
    input wire logic prog_entry, // Entry request
    input wire logic core_reset_n // Core reset
);
    // Decode of the four mapped words and of a taken configuration write
    wire logic mapped = paddr == {2'b00, STATUS_ADDR} || paddr == {2'b00, PWRCTL_ADDR}
        || paddr == {2'b00, CONFIG_ADDR} || paddr == {2'b00, EVENT_ADDR};
    wire logic cfg_wr = psel && penable && pready && pwrite && paddr == {2'b00, CONFIG_ADDR};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Single-cycle low excursions while the core runs
    sequence s_pin_glitch;
        core_reset_n && ext_reset_pin_in ##1 !ext_reset_pin_in ##1 ext_reset_pin_in;
    endsequence
    sequence s_supply_blip;
        core_reset_n && !supply_low ##1 supply_low ##1 !supply_low;
    endsequence
    chk_pin_never_driven: assert property (
        ext_reset_pin_oe_n && !ext_reset_pin_out) else $error("reset pin driven");
    chk_pullup_follows_cfg: assert property (
        cfg_wr |-> ##2 ext_reset_pin_pullup == !$past(pwdata[CFG_EXT_RESET_PIN_ENABLE_BIT], 2))
        else $error("pull-up does not follow pin enable");
    chk_pin_glitch_ignored: assert property (
        s_pin_glitch |-> core_reset_n [*4]) else $error("pin glitch reset the core");
    chk_supply_blip_ignored: assert property (
        s_supply_blip |-> core_reset_n [*4]) else $error("supply blip reset the core");
    chk_prog_entry_path: assert property (
        $rose(prog_entry_in) |=> prog_entry) else $error("entry request lost");
    chk_hold_after_por: assert property (
        $rose(presetn) |-> !core_reset_n [*8]) else $error("core left reset too early");
    chk_ready_one_wait: assert property (
        psel && !penable |=> pready) else $error("ready not in first access cycle");
    chk_ready_one_cycle: assert property (
        pready |=> !pready) else $error("ready stood too long");
    chk_err_unmapped: assert property (
        pready |-> pslverr == !mapped && (mapped || prdata == 32'h0))
        else $error("error response wrong");
endmodule
bind reset_timeout_sequencer rts_properties u_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_reset_pin_in,
    .ext_reset_pin_out, .ext_reset_pin_oe_n, .ext_reset_pin_pullup, .supply_low,
    .prog_entry_in, .prog_entry, .core_reset_n);

// [board_model.sv]
// Board model: reset switch with resistor to supply, and free-running oscillators
`timescale 1ns/100ps
module board_model #(
    parameter real LF_HALF = 32.0, // Scaled low-frequency half period, ns
    parameter real MAIN_HALF = 16.0 // Scaled main oscillator half period, ns
) (
    input wire logic hold_low, // Switch pulls the pin low
    input wire logic ext_reset_pin_out, // Device pin value
    input wire logic ext_reset_pin_oe_n, // Device pin enable, low drives
    output logic pin_level, // Resolved pin level
    output logic low_freq_internal_osc, // Low-frequency oscillator
    output logic main_osc // Main oscillator
);
    // Device drive wins, then the switch, else the resistor holds it high
    assign pin_level = !ext_reset_pin_oe_n ? ext_reset_pin_out : !hold_low;
    // Offset starts keep the oscillators out of step with the system clock
    initial begin
        low_freq_internal_osc = 1'b0;
        #1.3;
        forever #(LF_HALF) low_freq_internal_osc = ~low_freq_internal_osc;
    end
    initial begin
        main_osc = 1'b0;
        #0.7;
        forever #(MAIN_HALF) main_osc = ~main_osc;
    end
endmodule

// [reset_timeout_sequencer_test.sv]
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/100ps
module reset_timeout_sequencer_test;
    import rst_pkg::*;
    localparam int LF = 16;
    localparam int MN = 8;
    logic pclk, presetn, psel, penable, pwrite, hold_low, supply_low, err;
    logic watchdog_timeout, sleep_active, prog_entry_in, pready, pslverr;
    logic ext_reset_pin_in, ext_reset_pin_out, ext_reset_pin_oe_n, ext_reset_pin_pullup;
    logic low_freq_internal_osc, main_osc, prog_entry, core_reset_n;
    logic core_clk_internal, wake_pending;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Small counts keep the run short; the power-up and restart windows are derived from the counts of 4
    reset_timeout_sequencer #(.POWERUP_TIMER_COUNT(4), .OST_COUNT(4), .BOR_MIN_CYCLES(2)) uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_reset_pin_in, .ext_reset_pin_out, .ext_reset_pin_oe_n,
        .ext_reset_pin_pullup, .supply_low, .low_freq_internal_osc, .main_osc,
        .watchdog_timeout, .sleep_active, .prog_entry_in, .prog_entry, .core_reset_n,
        .core_clk_internal, .wake_pending);
    board_model u_board (.hold_low, .ext_reset_pin_out, .ext_reset_pin_oe_n,
        .pin_level(ext_reset_pin_in), .low_freq_internal_osc, .main_osc);
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, well above the roughly one thousand cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_time(input string what, input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic wait_core(output int k);
        k = 0;
        while (core_reset_n !== 1'b1) begin
            @(posedge pclk);
            k++;
        end
    endtask
    task automatic flags(input logic [7:0] exp);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check8("status flags", exp, rd[7:0] & 8'h18);
    endtask
    task automatic pin_reset(input logic slp);
        sleep_active <= slp;
        hold_low <= 1'b1;
        cyc(20);
        check8("pin held", 8'h0, {7'h0, core_reset_n});
        hold_low <= 1'b0;
        wait_core(n);
        check_time("pin release", n, 0, 12);
        sleep_active <= 1'b0;
    endtask
    task automatic dog();
        watchdog_timeout <= 1'b1;
        @(posedge pclk);
        watchdog_timeout <= 1'b0;
        cyc(10);
        wait_core(n);
    endtask
    // Long supply dip under a given mode; expect reset or not, and release time
    task automatic bor_try(input logic [7:0] cfg, input logic [7:0] pw, input logic slp,
        input logic ex, input int lo, input int hi);
        apb(1'b1, CONFIG_ADDR, {24'h0, cfg});
        apb(1'b1, PWRCTL_ADDR, {24'h0, pw});
        sleep_active <= slp;
        supply_low <= 1'b1;
        cyc(20);
        check8("dip held", {7'h0, !ex}, {7'h0, core_reset_n});
        supply_low <= 1'b0;
        wait_core(n);
        if (ex)
            check_time("dip release", n, lo, hi);
        sleep_active <= 1'b0;
        cyc(4);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, hold_low, supply_low} = 6'h0;
        {watchdog_timeout, sleep_active, prog_entry_in} = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        cyc(5);
        presetn <= 1'b1;
        wait_core(n);
        check_time("power-up", n, 3 * LF + 3 * MN, 5 * LF + 5 * MN + 20);
        flags(8'h18);
        apb(1'b0, PWRCTL_ADDR, 32'h0);
        check8("por flag", 8'h0, {7'h0, rd[POR_BIT]});
        apb(1'b0, CONFIG_ADDR, 32'h0);
        check8("config", CONFIG_RESET, rd[7:0]);
        apb(1'b0, 10'h3FC, 32'h0);
        check8("unmapped", 8'h1, {7'h0, err});
        apb(1'b1, PWRCTL_ADDR, 32'h13);
        apb(1'b0, PWRCTL_ADDR, 32'h0);
        check8("pwrctl", 8'h13, rd[7:0]);
        hold_low <= 1'b1;
        @(posedge pclk);
        hold_low <= 1'b0;
        cyc(8);
        check8("pin glitch", 8'h1, {7'h0, core_reset_n});
        pin_reset(1'b0);
        flags(8'h18);
        apb(1'b0, PWRCTL_ADDR, 32'h0);
        check8("por kept", 8'h1, {7'h0, rd[POR_BIT]});
        pin_reset(1'b1);
        flags(8'h10);
        dog();
        flags(8'h00);
        apb(1'b1, CONFIG_ADDR, 32'h3E);
        supply_low <= 1'b1;
        @(posedge pclk);
        supply_low <= 1'b0;
        cyc(8);
        check8("supply blip", 8'h1, {7'h0, core_reset_n});
        supply_low <= 1'b1;
        cyc(20);
        supply_low <= 1'b0;
        cyc(30);
        supply_low <= 1'b1;
        cyc(20);
        supply_low <= 1'b0;
        wait_core(n);
        check_time("restart", n, 3 * LF, 5 * LF + 30);
        apb(1'b0, PWRCTL_ADDR, 32'h0);
        check8("bor flag", 8'h0, {7'h0, rd[BOR_BIT]});
        flags(8'h18);
        sleep_active <= 1'b1;
        dog();
        sleep_active <= 1'b0;
        flags(8'h00);
        bor_try(8'h33, 8'h12, 1'b0, 1'b0, 0, 0);
        bor_try(8'h37, 8'h02, 1'b0, 1'b0, 0, 0);
        bor_try(8'h37, 8'h12, 1'b0, 1'b1, 0, 12);
        bor_try(8'h3B, 8'h12, 1'b1, 1'b0, 0, 0);
        bor_try(8'h3B, 8'h02, 1'b0, 1'b1, 0, 12);
        bor_try(8'h1F, 8'h12, 1'b0, 1'b1, 3 * MN, 5 * MN + 20);
        // Watchdog wake in a crystal mode runs the start-up count only
        sleep_active <= 1'b1;
        watchdog_timeout <= 1'b1;
        cyc(1);
        watchdog_timeout <= 1'b0;
        cyc(3);
        check8("wake count", 8'h1, {7'h0, wake_pending});
        sleep_active <= 1'b0;
        cyc(60);
        check8("wake done", 8'h0, {7'h0, wake_pending});
        bor_try(8'h9F, 8'h12, 1'b0, 1'b1, 0, 12);
        check8("internal clock", 8'h1, {7'h0, core_clk_internal});
        cyc(60);
        check8("internal clock off", 8'h0, {7'h0, core_clk_internal});
        apb(1'b1, CONFIG_ADDR, 32'h30);
        cyc(2);
        check8("pull-up", 8'h1, {7'h0, ext_reset_pin_pullup});
        hold_low <= 1'b1;
        prog_entry_in <= 1'b1;
        cyc(20);
        check8("pin tied", 8'h1, {7'h0, core_reset_n});
        check8("entry", 8'h1, {7'h0, prog_entry});
        prog_entry_in <= 1'b0;
        presetn <= 1'b0;
        cyc(5);
        presetn <= 1'b1;
        cyc(200);
        check8("pin holds", 8'h0, {7'h0, core_reset_n});
        hold_low <= 1'b0;
        wait_core(n);
        check_time("late pin", n, 0, 8);
        print_verdict();
    end
endmodule
